// >>> dv/dacif_bus_asserts.sv
`timescale 1ns/1ns
module dacif_bus_asserts (
  input  wire logic mclk_i,
  input  wire logic rst_i,
  input  wire logic scl_oe_n_m,
  input  wire logic sda_oe_n_m,
  input  wire logic sda_o_s,
  input  wire logic sda_oe_n_s,
  input  wire logic scl,
  input  wire logic sda
);
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (rst_i);
  // ==========================================================
  // scl rises since last start
  logic [7:0] pulses;
  // saturates so a runaway bus cannot wrap back to a legal count
  always_ff @(posedge mclk_i) begin
    if (rst_i || ($fell(sda) && scl)) begin
      pulses <= 8'h00;
    end else if ($rose(scl) && pulses != 8'hFF) begin
      pulses <= pulses + 8'h01;
    end
  end
  // ==========================================================
  // bus checks
  a_idle_after_reset: assert property ($fell(rst_i) |-> scl_oe_n_m && sda_oe_n_m && sda_oe_n_s)
    else $error("bus not released after reset");
  a_slave_low_only: assert property (!sda_oe_n_s |-> !sda_o_s)
    else $error("slave drives sda high");
  a_slave_edge_low: assert property (scl && $past(scl) |-> $stable(sda_oe_n_s))
    else $error("slave sda changed while scl high");
  a_ack_starts_low: assert property ($fell(sda_oe_n_s) |-> !scl)
    else $error("slave drive began with scl high");
  a_drive_holds_high: assert property ($rose(scl) && !sda_oe_n_s |-> !sda_oe_n_s [*8])
    else $error("slave drive dropped during pulse");
  a_ack_ninth_pulse: assert property ($rose(scl) && pulses == 8'h08 |-> !sda_oe_n_s)
    else $error("no ack on ninth pulse");
  a_start_then_clock: assert property ($fell(sda) && scl |-> ##[1:1000] !scl)
    else $error("no clocking after start");
  a_stop_stays_idle: assert property ($rose(sda) && scl |-> (scl && sda && sda_oe_n_s) [*8])
    else $error("bus not idle after stop");
  a_frame_pulses: assert property ($rose(sda) && scl |-> pulses == 8'h1C)
    else $error("frame pulse count wrong");
endmodule : dacif_bus_asserts

// >>> dv/tb_top.sv
`timescale 1ns/1ns
module tb_top;
  logic        mclk_i  = 1'b0;
  logic        rst_i   = 1'b1;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [31:0] paddr   = 32'h0;
  logic [31:0] pwdata  = 32'h0;
  logic        pd_pin  = 1'b0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [15:0] word;
  logic [9:0]  code;
  logic        pdc;
  logic        pdn;
  logic        upd;
  logic [26:0] wbits;
  int          n_bits  = 27;
  int          n_stops = 0;
  int          n_upd   = 0;
  int          fails   = 0;
  int          n_checks = 0;
  // ==========================================================
  // design
  dacif_bus_if i_dacif_bus_if ();
  dacif_master i_dacif_master (.mclk_i(mclk_i), .rst_i(rst_i), .ce_i(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .bus(i_dacif_bus_if.master));
  dacif_slave i_dacif_slave (.mclk_i(mclk_i), .rst_i(rst_i), .ce_i(1'b1), .pd_pin_i(pd_pin),
    .bus(i_dacif_bus_if.slave), .dac_input_word_o(word), .dac_code_bits_o(code),
    .power_down_control_o(pdc), .powered_down_o(pdn), .dac_update_o(upd));
  dacif_bus_asserts i_dacif_bus_asserts (.mclk_i(mclk_i), .rst_i(rst_i),
    .scl_oe_n_m(i_dacif_bus_if.scl_oe_n_m), .sda_oe_n_m(i_dacif_bus_if.sda_oe_n_m),
    .sda_o_s(i_dacif_bus_if.sda_o_s), .sda_oe_n_s(i_dacif_bus_if.sda_oe_n_s),
    .scl(i_dacif_bus_if.scl), .sda(i_dacif_bus_if.sda));
  always #2 mclk_i = ~mclk_i;
  // ==========================================================
  // wire monitor: first 27 bits after each start
  always @(negedge i_dacif_bus_if.sda) if (i_dacif_bus_if.scl === 1'b1) n_bits = 0;
  always @(posedge i_dacif_bus_if.sda) if (i_dacif_bus_if.scl === 1'b1) n_stops++;
  always @(posedge i_dacif_bus_if.scl) begin
    if (n_bits < 27) begin
      wbits = {wbits[25:0], i_dacif_bus_if.sda};
      n_bits++;
    end
  end
  always @(posedge mclk_i) if (upd === 1'b1) n_upd++;
  // ==========================================================
  // helpers
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : test_done
  // pready is sampled with the value it holds at the rising edge
  task automatic apb(input logic wr, input logic [3:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic err);
    int   k;
    logic rdy;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= {28'h0, a};
    pwdata  <= d;
    @(posedge mclk_i);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge mclk_i);
      rdy = pready;
      q   = prdata;
      err = pslverr;
      k++;
    end while (rdy !== 1'b1 && k < 50);
    if (rdy !== 1'b1) begin
      fails++;
      test_done();
    end
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk_i);
  endtask : apb
  task automatic xfer(input logic rdn, input logic [1:0] alt, input logic [15:0] w,
                      output logic [15:0] got);
    logic [31:0] q;
    logic        e;
    int          k;
    int          s0;
    s0 = n_stops;
    apb(1'b1, dacif_pkg::REG_WDATA, {16'h0, w}, q, e);
    apb(1'b1, dacif_pkg::REG_CTRL, {28'h0, alt, rdn, 1'b1}, q, e);
    apb(1'b0, dacif_pkg::REG_STATUS, 32'h0, q, e);
    check({31'h0, q[dacif_pkg::STAT_BUSY]}, 32'h1);
    k = 0;
    do begin
      apb(1'b0, dacif_pkg::REG_STATUS, 32'h0, q, e);
      k++;
    end while (q[dacif_pkg::STAT_BUSY] !== 1'b0 && k < 20000);
    if (q[dacif_pkg::STAT_BUSY] !== 1'b0) begin
      fails++;
      test_done();
    end
    check({31'h0, q[dacif_pkg::STAT_NACK]}, 32'h0);
    check({24'h0, wbits[26:19]}, {24'h0, dacif_pkg::ADDR_HI, alt, rdn});
    check({5'h0, wbits}, {5'h0, dacif_pkg::ADDR_HI, alt, rdn, 1'b0, w[15:8], 1'b0, w[7:0], rdn});
    check(n_stops, s0 + 1);
    check({30'h0, i_dacif_bus_if.scl, i_dacif_bus_if.sda}, 32'h3);
    apb(1'b0, dacif_pkg::REG_RDATA, 32'h0, q, e);
    got = q[15:0];
  endtask : xfer
  // ==========================================================
  // scenarios
  task automatic t_regs();
    logic [31:0] q;
    logic        e;
    apb(1'b0, 4'h2, 32'h0, q, e);
    check({q[30:0], e}, 32'h1);
    apb(1'b1, 4'h0, 32'h0, q, e);
    apb(1'b0, 4'h0, 32'h0, q, e);
    check({q[30:0], e}, 32'h0);
  endtask : t_regs
  task automatic t_write_pd();
    logic [15:0] g;
    xfer(1'b0, 2'h0, 16'hABCD, g);
    check({16'h0, word}, 32'hABCD);
    check({22'h0, code}, 32'h2BC);
    check({30'h0, pdc, pdn}, 32'h3);
    check(n_upd, 1);
  endtask : t_write_pd
  task automatic t_read_clear();
    logic [15:0] g;
    xfer(1'b1, 2'h1, 16'hABCD, g);
    check({16'h0, g}, 32'hABCD);
    check({16'h0, word}, 32'h0);
    check({22'h0, code}, 32'h2BC);
    check(n_upd, 1);
  endtask : t_read_clear
  task automatic t_write_alt();
    logic [15:0] g;
    xfer(1'b0, 2'h3, 16'h4FF5, g);
    check({22'h0, code}, 32'h0FF);
    check({30'h0, pdc, pdn}, 32'h0);
    pd_pin <= 1'b1;
    #1;
    check({30'h0, pdc, pdn}, 32'h1);
    @(posedge mclk_i);
    pd_pin <= 1'b0;
    @(posedge mclk_i);
    check({30'h0, pdc, pdn}, 32'h0);
  endtask : t_write_alt
  // ==========================================================
  // main sequence
  initial begin
    repeat (2) @(posedge mclk_i);
    rst_i <= 1'b0;
    @(posedge mclk_i);
    n_stops = 0;
    t_regs();
    t_write_pd();
    t_read_clear();
    t_write_alt();
    test_done();
  end
endmodule : tb_top

// >>> pkg/dacif_bus_if.sv
`timescale 1ns/1ns
interface dacif_bus_if;
  logic scl_o_m;
  logic scl_oe_n_m;
  logic sda_o_m;
  logic sda_oe_n_m;
  logic sda_o_s;
  logic sda_oe_n_s;
  // open drain: low wins, pull-up otherwise
  wire scl = ~(!scl_oe_n_m && !scl_o_m);
  wire sda = ~((!sda_oe_n_m && !sda_o_m) || (!sda_oe_n_s && !sda_o_s));
  modport master (output scl_o_m, output scl_oe_n_m, output sda_o_m, output sda_oe_n_m,
                  input scl, input sda);
  modport slave  (output sda_o_s, output sda_oe_n_s, input scl, input sda);
endinterface : dacif_bus_if

// >>> pkg/dacif_pkg.sv
package dacif_pkg;
  // ==========================================================
  // bus addressing
  localparam logic [4:0]  ADDR_HI        = 5'h03;
  localparam logic [7:0]  ADDR_WR_BYTE   = 8'h18;
  localparam logic [7:0]  ADDR_RD_BYTE   = 8'h19;
  // ==========================================================
  // input word layout
  localparam int          PD_BIT         = 15;
  localparam int          CODE_MSB       = 13;
  localparam int          CODE_LSB       = 4;
  localparam logic [15:0] WORD_RESET     = 16'h0000;
  // ==========================================================
  // master register map (apb byte addresses)
  localparam logic [3:0]  REG_CTRL       = 4'h0;
  localparam logic [3:0]  REG_WDATA      = 4'h4;
  localparam logic [3:0]  REG_STATUS     = 4'h8;
  localparam logic [3:0]  REG_RDATA      = 4'hC;
  localparam int          CTRL_GO        = 0;
  localparam int          CTRL_READ      = 1;
  localparam int          CTRL_ALT_LO    = 2;
  localparam int          STAT_BUSY      = 0;
  localparam int          STAT_NACK      = 1;
  // ==========================================================
  // timing
  localparam int          CLK_NS         = 4;
  localparam int          SCL_HALF_NS    = 1248;
  localparam int          SCL_HALF_CYC   = SCL_HALF_NS / CLK_NS;
  localparam int          CNT_W          = 9;
endpackage : dacif_pkg

// >>> src/dacif_master.sv
// Added by the designer: the APB interface to the registers and the register addresses.
`timescale 1ns/1ns
module dacif_master (
  input  wire logic        mclk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  dacif_bus_if.master      bus
);
  typedef enum logic [2:0] {
    DACIF_M_IDLE = 3'b000, DACIF_M_START = 3'b001, DACIF_M_BIT = 3'b010,
    DACIF_M_STOP = 3'b011, DACIF_M_DONE = 3'b100
  } dacif_m_st_t;

  // ==========================================================
  // registers
  logic        rd_op;
  logic [1:0]  alt;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic        busy;
  logic        nack;
  logic        go;
  wire acc = psel & penable;
  wire [3:0] a = paddr[3:0];
  // unmapped or unaligned word
  function automatic logic dacif_bad_addr(input logic [31:0] addr);
    dacif_bad_addr = (addr[31:4] != 28'h0000000) || (addr[1:0] != 2'h0);
  endfunction : dacif_bad_addr
  assign pready = 1'b1;
  assign pslverr = acc && dacif_bad_addr(paddr);
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      rd_op <= 1'b0;
      alt <= 2'h0;
      wdata <= 16'h0000;
      go <= 1'b0;
      prdata <= 32'h00000000;
    end else if (ce_i) begin
      go <= 1'b0;
      if (acc && pwrite && !pslverr) begin
        if (a == dacif_pkg::REG_CTRL && !busy) begin
          go <= pwdata[dacif_pkg::CTRL_GO];
          rd_op <= pwdata[dacif_pkg::CTRL_READ];
          alt <= pwdata[dacif_pkg::CTRL_ALT_LO +: 2];
        end
        if (a == dacif_pkg::REG_WDATA)
          wdata <= pwdata[15:0];
      end
      // read data loads in setup so it stands through the zero-wait access
      if (psel && !penable && !pwrite) begin
        if (dacif_bad_addr(paddr)) begin
          prdata <= 32'h00000000;
        end else begin
          case (a)
            dacif_pkg::REG_CTRL:   prdata <= {29'h0, alt, rd_op};
            dacif_pkg::REG_WDATA:  prdata <= {16'h0000, wdata};
            dacif_pkg::REG_STATUS: prdata <= {30'h0, nack, busy};
            dacif_pkg::REG_RDATA:  prdata <= {16'h0000, rdata};
            default:               prdata <= 32'h00000000;
          endcase
        end
      end
    end
  end

  // ==========================================================
  // bit engine: each bit is four quarter phases of scl
  dacif_m_st_t st;
  logic [dacif_pkg::CNT_W-1:0] cnt;
  logic [1:0]  ph;
  logic [1:0]  byten;
  logic [3:0]  bitn;
  logic [7:0]  tx;
  logic        scl_r;
  logic        sda_r;
  logic [1:0]  sda_s;
  wire tick = (cnt == dacif_pkg::CNT_W'(dacif_pkg::SCL_HALF_CYC / 2 - 1));
  wire [7:0] addr_b = {dacif_pkg::ADDR_HI, alt, rd_op};
  wire is_ack = (bitn == 4'h8);
  wire m_drive_ack = rd_op && byten != 2'h0 && is_ack && byten == 2'h1;

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      sda_s <= 2'h3;
    end else if (ce_i) begin
      sda_s <= {sda_s[0], bus.sda};
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      st <= DACIF_M_IDLE;
      cnt <= '0;
      ph <= 2'h0;
      byten <= 2'h0;
      bitn <= 4'h0;
      tx <= 8'h00;
      scl_r <= 1'b1;
      sda_r <= 1'b1;
      busy <= 1'b0;
      nack <= 1'b0;
      rdata <= 16'h0000;
    end else if (ce_i) begin
      cnt <= tick ? '0 : cnt + 1'b1;
      case (st)
        DACIF_M_IDLE: begin
          scl_r <= 1'b1;
          sda_r <= 1'b1;
          if (go) begin
            busy <= 1'b1;
            nack <= 1'b0;
            st <= DACIF_M_START;
            ph <= 2'h0;
          end
        end
        DACIF_M_START: if (tick) begin
          // start: sda falls with scl high
          sda_r <= 1'b0;
          tx <= addr_b;
          byten <= 2'h0;
          bitn <= 4'h0;
          ph <= 2'h0;
          st <= DACIF_M_BIT;
        end
        DACIF_M_BIT: if (tick) begin
          ph <= ph + 2'h1;
          case (ph)
            2'h0: scl_r <= 1'b0;
            2'h1: begin
              // data changes only with scl low
              if (is_ack)
                sda_r <= ~m_drive_ack;
              else if (rd_op && byten != 2'h0)
                sda_r <= 1'b1;
              else
                sda_r <= tx[7];
            end
            2'h2: scl_r <= 1'b1;
            default: begin
              if (is_ack) begin
                if ((byten == 2'h0 || !rd_op) && sda_s[1])
                  nack <= 1'b1;
                bitn <= 4'h0;
                byten <= byten + 2'h1;
                tx <= byten == 2'h0 ? wdata[15:8] : wdata[7:0];
                if (byten == 2'h2 || ((byten == 2'h0 || !rd_op) && sda_s[1]))
                  st <= DACIF_M_STOP;
              end else begin
                if (rd_op && byten != 2'h0)
                  rdata <= {rdata[14:0], sda_s[1]};
                tx <= {tx[6:0], 1'b0};
                bitn <= bitn + 4'h1;
              end
            end
          endcase
        end
        DACIF_M_STOP: if (tick) begin
          ph <= ph + 2'h1;
          case (ph)
            2'h0: scl_r <= 1'b0;
            2'h1: sda_r <= 1'b0;
            2'h2: scl_r <= 1'b1;
            default: begin
              sda_r <= 1'b1;
              st <= DACIF_M_DONE;
            end
          endcase
        end
        DACIF_M_DONE: if (tick) begin
          busy <= 1'b0;
          st <= DACIF_M_IDLE;
        end
        default: st <= DACIF_M_IDLE;
      endcase
    end
  end

  assign bus.scl_o_m = 1'b0;
  assign bus.scl_oe_n_m = scl_r;
  assign bus.sda_o_m = 1'b0;
  assign bus.sda_oe_n_m = sda_r;
endmodule : dacif_master

// >>> src/dacif_slave.sv
`timescale 1ns/1ns
module dacif_slave (
  input  wire logic       mclk_i,
  input  wire logic       rst_i,
  input  wire logic       ce_i,
  input  wire logic       pd_pin_i,
  dacif_bus_if.slave      bus,
  output logic [15:0]     dac_input_word_o,
  output logic [9:0]      dac_code_bits_o,
  output logic            power_down_control_o,
  output logic            powered_down_o,
  output logic            dac_update_o
);
  typedef enum logic [2:0] {
    DACIF_IDLE = 3'b000, DACIF_ADDR = 3'b001, DACIF_WR = 3'b010,
    DACIF_RD   = 3'b011, DACIF_SKIP = 3'b100
  } dacif_st_t;

  // ==========================================================
  // pin synchronisers
  logic [1:0] scl_s;
  logic [1:0] sda_s;
  logic       scl_q;
  logic       sda_q;
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      scl_s <= 2'h3;
      sda_s <= 2'h3;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else if (ce_i) begin
      scl_s <= {scl_s[0], bus.scl};
      sda_s <= {sda_s[0], bus.sda};
      scl_q <= scl_s[1];
      sda_q <= sda_s[1];
    end
  end
  wire scl_rise = scl_s[1] & ~scl_q;
  wire scl_fall = ~scl_s[1] & scl_q;
  wire start_c  = scl_s[1] & scl_q & sda_q & ~sda_s[1];
  wire stop_c   = scl_s[1] & scl_q & ~sda_q & sda_s[1];

  // ==========================================================
  // protocol state
  dacif_st_t   st;
  logic [3:0]  bitn;
  logic [7:0]  sh;
  logic [1:0]  nbytes;
  logic        ack_ph;
  logic        mack;
  logic [15:0] word;
  logic [15:0] dac_reg;
  logic        sda_drv;

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      st <= DACIF_IDLE;
      bitn <= 4'h0;
      sh <= 8'h00;
      nbytes <= 2'h0;
      ack_ph <= 1'b0;
      mack <= 1'b0;
      word <= dacif_pkg::WORD_RESET;
      dac_reg <= dacif_pkg::WORD_RESET;
      dac_update_o <= 1'b0;
      sda_drv <= 1'b0;
    end else if (ce_i) begin
      dac_update_o <= 1'b0;
      if (start_c) begin
        st <= DACIF_ADDR;
        bitn <= 4'h0;
        nbytes <= 2'h0;
        ack_ph <= 1'b0;
        sda_drv <= 1'b0;
      end else if (stop_c) begin
        // clear word after read
        // a finished read has already dropped to skip on the nacked byte
        if ((st == DACIF_RD || st == DACIF_SKIP) && nbytes == 2'h2)
          word <= dacif_pkg::WORD_RESET;
        st <= DACIF_IDLE;
        sda_drv <= 1'b0;
      end else begin
        case (st)
          DACIF_ADDR, DACIF_WR: begin
            if (scl_rise && !ack_ph) begin
              sh <= {sh[6:0], sda_q};
              bitn <= bitn + 4'h1;
            end
            if (scl_fall && !ack_ph && bitn == 4'h8) begin
              ack_ph <= 1'b1;
              bitn <= 4'h0;
              if (st == DACIF_ADDR) begin
                if (sh[7:3] == dacif_pkg::ADDR_HI) begin
                  sda_drv <= 1'b1;
                end else begin
                  st <= DACIF_SKIP;
                end
              end else if (nbytes != 2'h2) begin
                word <= {word[7:0], sh};
                nbytes <= nbytes + 2'h1;
                sda_drv <= 1'b1;
                if (nbytes == 2'h1) begin
                  dac_reg <= {word[7:0], sh};
                  dac_update_o <= 1'b1;
                end
              end
            end else if (scl_fall && ack_ph) begin
              ack_ph <= 1'b0;
              sda_drv <= 1'b0;
              if (st == DACIF_ADDR) begin
                st <= sh[0] ? DACIF_RD : DACIF_WR;
                if (sh[0])
                  sda_drv <= ~word[15];
                bitn <= sh[0] ? 4'h1 : 4'h0;
              end
            end
          end
          DACIF_RD: begin
            if (scl_rise && ack_ph) begin
              mack <= ~sda_q;
            end
            if (scl_fall && !ack_ph) begin
              if (bitn == 4'h8) begin
                ack_ph <= 1'b1;
                sda_drv <= 1'b0;
                nbytes <= nbytes + 2'h1;
                bitn <= 4'h0;
              end else begin
                sda_drv <= ~word[4'hF - {nbytes[0], bitn[2:0]}];
                bitn <= bitn + 4'h1;
              end
            end else if (scl_fall && ack_ph) begin
              ack_ph <= 1'b0;
              if (nbytes == 2'h1 && mack) begin
                sda_drv <= ~word[7];
                bitn <= 4'h1;
              end else begin
                st <= DACIF_SKIP;
              end
            end
          end
          DACIF_SKIP: sda_drv <= 1'b0;
          default: st <= DACIF_IDLE;
        endcase
      end
    end
  end

  assign bus.sda_o_s = 1'b0;
  assign bus.sda_oe_n_s = ~sda_drv;

  assign dac_input_word_o = word;
  assign dac_code_bits_o = dac_reg[dacif_pkg::CODE_MSB:dacif_pkg::CODE_LSB];
  assign power_down_control_o = dac_reg[dacif_pkg::PD_BIT];
  assign powered_down_o = pd_pin_i | dac_reg[dacif_pkg::PD_BIT];
endmodule : dacif_slave
